// ==== design/nvm_access_ctrl.sv ====
// memory access end: registers, unlock detector, write timer, array, external port
//
// What this block does
// - read trigger loads addressed byte next cycle
// - data register holds until read or write
// - software loads address and data before writing
// - write starts only after keys then trigger
// - no other write between keys and trigger
// - trigger refused while write permit clear
// - permit and trigger together start nothing
// - hardware never clears the write permit
// - software keeps permit clear outside updates
// - control, address, data locked during write
// - completion clears trigger, sets complete flag
// - complete flag stays until software clears
// - code protect blocks external accesses
// - processor accesses ignore code protect
// - reset clears the write permit
// - writes blocked during power-up timer
// - unlock port holds no readable state
`timescale 1ns/100ps
`default_nettype none
module nvm_access_ctrl
    import nvm_access_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES,
    parameter int POWER_UP_CYCLES_P = POWER_UP_CYCLES,
    parameter int DEPTH = 256
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // processor link
    nvm_bus_if.dev bus,
    // configuration
    input wire logic code_protect_i,
    // external programming port
    input wire logic ext_rd_i,
    input wire logic ext_wr_i,
    input wire logic [7:0] ext_addr_i,
    input wire logic [7:0] ext_wdata_i,
    output logic [7:0] ext_rdata_o,
    output logic ext_ack_o,
    output logic ext_denied_o,
    // status
    output logic write_busy_o
);
    localparam int WCW = $clog2(WRITE_CYCLES_P + 1);
    localparam int PCW = $clog2(POWER_UP_CYCLES_P + 1);
    localparam logic [WCW-1:0] WRITE_LOAD = WCW'(WRITE_CYCLES_P);
    localparam logic [PCW-1:0] POWER_UP_LAST = PCW'(POWER_UP_CYCLES_P);

    typedef struct packed {
        logic [7:0] address;
        logic [7:0] data;
        logic program_memory_select;
        logic config_space_select;
        logic write_abort_flag;
        logic write_permit;
        logic busy;
        key_state_t key;
        logic write_complete_flag;
        logic write_complete_irq_enable;
        logic write_complete_irq_priority;
        logic [WCW-1:0] write_count;
        logic [PCW-1:0] power_up_count;
        logic power_up_done;
        logic [7:0] rdata;
        logic irq_high;
        logic irq_low;
        logic [7:0] ext_rdata;
        logic ext_ack;
        logic ext_denied;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;
    logic [7:0] mem [DEPTH];
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic ctrl_wr;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_waddr = s_q.address;
        mem_wdata = s_q.data;
        s_d.rdata = RESET_BYTE;
        s_d.ext_ack = 1'b0;
        s_d.ext_denied = 1'b0;
        ctrl_wr = bus.wr && bus.addr == REG_CONTROL && !s_q.busy;
        // power-up timer
        if (!s_q.power_up_done) begin
            s_d.power_up_count = s_q.power_up_count + PCW'(1);
            s_d.power_up_done = s_d.power_up_count == POWER_UP_LAST;
        end
        // register reads
        if (bus.rd) begin
            unique case (bus.addr)
                REG_ADDRESS: s_d.rdata = s_q.address;
                REG_DATA: s_d.rdata = s_q.data;
                REG_CONTROL: begin
                    s_d.rdata[CTRL_PROGRAM_MEMORY_SELECT] = s_q.program_memory_select;
                    s_d.rdata[CTRL_CONFIG_SPACE_SELECT] = s_q.config_space_select;
                    s_d.rdata[CTRL_WRITE_ABORT_FLAG] = s_q.write_abort_flag;
                    s_d.rdata[CTRL_WRITE_PERMIT] = s_q.write_permit;
                    s_d.rdata[CTRL_WRITE_TRIGGER] = s_q.busy;
                end
                REG_FLAGS_B: s_d.rdata[IRQ_WRITE_COMPLETE] = s_q.write_complete_flag;
                REG_ENABLES_B: s_d.rdata[IRQ_WRITE_COMPLETE] = s_q.write_complete_irq_enable;
                REG_PRIORITIES_B: s_d.rdata[IRQ_WRITE_COMPLETE] = s_q.write_complete_irq_priority;
                default: s_d.rdata = RESET_BYTE;
            endcase
        end
        // unlock detector: any write breaks a partial sequence
        if (bus.wr) begin
            s_d.key = KEY_IDLE;
            if (bus.addr == REG_UNLOCK && !s_q.busy) begin
                if (bus.wdata == KEY_FIRST) begin
                    s_d.key = KEY_GOT_FIRST;
                end else if (bus.wdata == KEY_SECOND && s_q.key == KEY_GOT_FIRST) begin
                    s_d.key = KEY_ARMED;
                end
            end
        end
        // register writes; address, data and control locked while a write runs
        if (bus.wr && !s_q.busy) begin
            if (bus.addr == REG_ADDRESS) begin
                s_d.address = bus.wdata;
            end
            if (bus.addr == REG_DATA) begin
                s_d.data = bus.wdata;
            end
        end
        if (ctrl_wr) begin
            s_d.program_memory_select = bus.wdata[CTRL_PROGRAM_MEMORY_SELECT];
            s_d.config_space_select = bus.wdata[CTRL_CONFIG_SPACE_SELECT];
            s_d.write_abort_flag = s_q.write_abort_flag & bus.wdata[CTRL_WRITE_ABORT_FLAG];
            s_d.write_permit = bus.wdata[CTRL_WRITE_PERMIT];
            if (bus.wdata[CTRL_READ_TRIGGER] && !bus.wdata[CTRL_PROGRAM_MEMORY_SELECT]
                && !bus.wdata[CTRL_CONFIG_SPACE_SELECT]) begin
                s_d.data = mem[s_q.address];
            end
            // old permit value decides, so permit and trigger together fail
            if (bus.wdata[CTRL_WRITE_TRIGGER] && s_q.key == KEY_ARMED && s_q.write_permit
                && !bus.wdata[CTRL_PROGRAM_MEMORY_SELECT] && !bus.wdata[CTRL_CONFIG_SPACE_SELECT]) begin
                if (s_q.power_up_done) begin
                    s_d.busy = 1'b1;
                    s_d.write_count = WRITE_LOAD;
                end else begin
                    s_d.write_abort_flag = 1'b1;
                end
            end
        end
        if (bus.wr && bus.addr == REG_ENABLES_B) begin
            s_d.write_complete_irq_enable = bus.wdata[IRQ_WRITE_COMPLETE];
        end
        if (bus.wr && bus.addr == REG_PRIORITIES_B) begin
            s_d.write_complete_irq_priority = bus.wdata[IRQ_WRITE_COMPLETE];
        end
        if (bus.wr && bus.addr == REG_FLAGS_B) begin
            s_d.write_complete_flag = bus.wdata[IRQ_WRITE_COMPLETE];
        end
        // write cycle timer; completion set wins over a clearing write
        if (s_q.busy) begin
            s_d.write_count = s_q.write_count - WCW'(1);
            if (s_q.write_count == WCW'(1)) begin
                mem_we = 1'b1;
                s_d.busy = 1'b0;
                s_d.write_complete_flag = 1'b1;
            end
        end
        // external programming port
        if (ext_rd_i) begin
            if (code_protect_i) begin
                s_d.ext_denied = 1'b1;
            end else begin
                s_d.ext_rdata = mem[ext_addr_i];
                s_d.ext_ack = 1'b1;
            end
        end else if (ext_wr_i) begin
            if (code_protect_i || s_q.busy || !s_q.power_up_done) begin
                s_d.ext_denied = 1'b1;
            end else begin
                mem_we = 1'b1;
                mem_waddr = ext_addr_i;
                mem_wdata = ext_wdata_i;
                s_d.ext_ack = 1'b1;
            end
        end
        // interrupt requests
        s_d.irq_high = s_d.write_complete_flag & s_d.write_complete_irq_enable
                       & s_d.write_complete_irq_priority;
        s_d.irq_low = s_d.write_complete_flag & s_d.write_complete_irq_enable
                      & !s_d.write_complete_irq_priority;
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory array, keeps its contents across reset
    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign bus.rdata = s_q.rdata;
    assign bus.irq_high = s_q.irq_high;
    assign bus.irq_low = s_q.irq_low;
    assign ext_rdata_o = s_q.ext_rdata;
    assign ext_ack_o = s_q.ext_ack;
    assign ext_denied_o = s_q.ext_denied;
    assign write_busy_o = s_q.busy;
endmodule
`default_nettype wire

// ==== design/nvm_access_pkg.sv ====
// shared constants and types for the data nonvolatile memory access link
package nvm_access_pkg;
    // device register indices on the processor link
    localparam logic [2:0] REG_ADDRESS = 3'h0;
    localparam logic [2:0] REG_DATA = 3'h1;
    localparam logic [2:0] REG_CONTROL = 3'h2;
    localparam logic [2:0] REG_UNLOCK = 3'h3;
    localparam logic [2:0] REG_FLAGS_B = 3'h4;
    localparam logic [2:0] REG_ENABLES_B = 3'h5;
    localparam logic [2:0] REG_PRIORITIES_B = 3'h6;
    // control register fields
    localparam int CTRL_PROGRAM_MEMORY_SELECT = 7;
    localparam int CTRL_CONFIG_SPACE_SELECT = 6;
    localparam int CTRL_WRITE_ABORT_FLAG = 3;
    localparam int CTRL_WRITE_PERMIT = 2;
    localparam int CTRL_WRITE_TRIGGER = 1;
    localparam int CTRL_READ_TRIGGER = 0;
    // write complete bit in flags, enables and priorities
    localparam int IRQ_WRITE_COMPLETE = 4;
    // unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WRITE_TIME_US = 2000;
    localparam int POWER_UP_TIMER_PERIOD_US = 64;
    localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYCLES = (POWER_UP_TIMER_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // controller command port register indices
    localparam logic [2:0] HREG_COMMAND = 3'h0;
    localparam logic [2:0] HREG_ADDRESS = 3'h1;
    localparam logic [2:0] HREG_WRITE_DATA = 3'h2;
    localparam logic [2:0] HREG_READ_DATA = 3'h3;
    localparam logic [2:0] HREG_STATUS = 3'h4;
    localparam logic [2:0] HREG_MASK = 3'h5;
    localparam int CMD_READ = 0;
    localparam int CMD_WRITE = 1;
    localparam int ST_READ_DONE = 0;
    localparam int ST_WRITE_DONE = 1;
    localparam int ST_BUSY = 2;
    // unlock sequence detector
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
endpackage

// ==== design/nvm_bus_if.sv ====
// register link between the processor end and the memory access end
`timescale 1ns/100ps
`default_nettype none
interface nvm_bus_if;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic irq_high;
    logic irq_low;
    modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq_high, output irq_low);
    modport cpu (output addr, output wdata, output wr, output rd, input rdata, input irq_high, input irq_low);
endinterface
`default_nettype wire

// ==== design/nvm_cpu_end.sv ====
// processor end: runs read and write sequences on command, with status and interrupt
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module nvm_cpu_end
    import nvm_access_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // processor link
    nvm_bus_if.cpu bus,
    // software command port
    input wire logic [2:0] sw_addr_i,
    input wire logic [7:0] sw_wdata_i,
    input wire logic sw_we_i,
    input wire logic sw_re_i,
    output logic [7:0] sw_rdata_o,
    // interrupt
    output logic irq_o
);
    typedef enum logic [4:0] {
        H_IDLE, W_ADDR, W_DATA, W_IRQ_ENABLE, W_IRQ_LEVEL, W_PERMIT, W_KEY1, W_KEY2, W_TRIG, W_POLL,
        W_POLL_WAIT, W_POLL_CHK, W_CLR_PERMIT, W_CLR_FLAG, R_ADDR, R_CTRL, R_DATA, R_WAIT, R_TAKE
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic [7:0] target;
        logic [7:0] value;
        logic [7:0] result;
        logic read_done;
        logic write_done;
        logic [1:0] mask;
        logic [7:0] sw_rdata;
        logic irq;
    } host_t;

    host_t h_q;
    host_t h_d;
    logic set_rdone;
    logic set_wdone;

    // one link write issued in the next cycle
    function automatic host_t issue_wr(host_t h, logic [2:0] a, logic [7:0] d);
        host_t r;
        r = h;
        r.addr = a;
        r.wdata = d;
        r.wr = 1'b1;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        h_d = h_q;
        h_d.wr = 1'b0;
        h_d.rd = 1'b0;
        h_d.sw_rdata = RESET_BYTE;
        set_rdone = 1'b0;
        set_wdone = 1'b0;
        unique case (h_q.state)
            H_IDLE: begin
                if (sw_we_i && sw_addr_i == HREG_COMMAND) begin
                    if (sw_wdata_i[CMD_WRITE]) begin
                        h_d.state = W_ADDR;
                    end else if (sw_wdata_i[CMD_READ]) begin
                        h_d.state = R_ADDR;
                    end
                end
            end
            W_ADDR: begin
                h_d = issue_wr(h_d, REG_ADDRESS, h_q.target);
                h_d.state = W_DATA;
            end
            W_DATA: begin
                h_d = issue_wr(h_d, REG_DATA, h_q.value);
                h_d.state = W_IRQ_ENABLE;
            end
            W_IRQ_ENABLE: begin
                h_d = issue_wr(h_d, REG_ENABLES_B, 8'h01 << IRQ_WRITE_COMPLETE);
                h_d.state = W_IRQ_LEVEL;
            end
            W_IRQ_LEVEL: begin
                // priority follows the lowest value bit so both request levels get used
                h_d = issue_wr(h_d, REG_PRIORITIES_B, 8'(h_q.value[0]) << IRQ_WRITE_COMPLETE);
                h_d.state = W_PERMIT;
            end
            W_PERMIT: begin
                h_d = issue_wr(h_d, REG_CONTROL, 8'h04);
                h_d.state = W_KEY1;
            end
            W_KEY1: begin
                h_d = issue_wr(h_d, REG_UNLOCK, KEY_FIRST);
                h_d.state = W_KEY2;
            end
            W_KEY2: begin
                h_d = issue_wr(h_d, REG_UNLOCK, KEY_SECOND);
                h_d.state = W_TRIG;
            end
            W_TRIG: begin
                h_d = issue_wr(h_d, REG_CONTROL, 8'h06);
                h_d.state = W_POLL;
            end
            W_POLL: begin
                h_d.addr = REG_CONTROL;
                h_d.rd = 1'b1;
                h_d.state = W_POLL_WAIT;
            end
            W_POLL_WAIT: h_d.state = W_POLL_CHK;
            W_POLL_CHK: begin
                h_d.state = bus.rdata[CTRL_WRITE_TRIGGER] ? W_POLL : W_CLR_PERMIT;
            end
            W_CLR_PERMIT: begin
                h_d = issue_wr(h_d, REG_CONTROL, 8'h00);
                h_d.state = W_CLR_FLAG;
            end
            W_CLR_FLAG: begin
                h_d = issue_wr(h_d, REG_FLAGS_B, 8'h00);
                h_d.state = H_IDLE;
                set_wdone = 1'b1;
            end
            R_ADDR: begin
                h_d = issue_wr(h_d, REG_ADDRESS, h_q.target);
                h_d.state = R_CTRL;
            end
            R_CTRL: begin
                h_d = issue_wr(h_d, REG_CONTROL, 8'h01);
                h_d.state = R_DATA;
            end
            R_DATA: begin
                h_d.addr = REG_DATA;
                h_d.rd = 1'b1;
                h_d.state = R_WAIT;
            end
            R_WAIT: h_d.state = R_TAKE;
            R_TAKE: h_d.state = H_IDLE;
            default: h_d.state = H_IDLE;
        endcase
        // software register access
        if (sw_we_i && h_q.state == H_IDLE) begin
            if (sw_addr_i == HREG_ADDRESS) begin
                h_d.target = sw_wdata_i;
            end
            if (sw_addr_i == HREG_WRITE_DATA) begin
                h_d.value = sw_wdata_i;
            end
        end
        if (sw_we_i && sw_addr_i == HREG_MASK) begin
            h_d.mask = sw_wdata_i[1:0];
        end
        if (sw_re_i) begin
            unique case (sw_addr_i)
                HREG_ADDRESS: h_d.sw_rdata = h_q.target;
                HREG_WRITE_DATA: h_d.sw_rdata = h_q.value;
                HREG_READ_DATA: h_d.sw_rdata = h_q.result;
                HREG_STATUS: begin
                    h_d.sw_rdata[ST_READ_DONE] = h_q.read_done;
                    h_d.sw_rdata[ST_WRITE_DONE] = h_q.write_done;
                    h_d.sw_rdata[ST_BUSY] = h_q.state != H_IDLE;
                    h_d.read_done = 1'b0;
                    h_d.write_done = 1'b0;
                end
                HREG_MASK: h_d.sw_rdata[1:0] = h_q.mask;
                default: h_d.sw_rdata = RESET_BYTE;
            endcase
        end
        // capture read result; events win over the clearing read
        if (h_q.state == R_TAKE) begin
            h_d.result = bus.rdata;
            set_rdone = 1'b1;
        end
        if (set_rdone) begin
            h_d.read_done = 1'b1;
        end
        if (set_wdone) begin
            h_d.write_done = 1'b1;
        end
        h_d.irq = (h_d.read_done & h_d.mask[ST_READ_DONE]) | (h_d.write_done & h_d.mask[ST_WRITE_DONE]);
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign bus.addr = h_q.addr;
    assign bus.wdata = h_q.wdata;
    assign bus.wr = h_q.wr;
    assign bus.rd = h_q.rd;
    assign sw_rdata_o = h_q.sw_rdata;
    assign irq_o = h_q.irq;
endmodule
`default_nettype wire

// ==== verif/nvm_access_properties.sv ====
// link checker for the memory access pair
`timescale 1ns/100ps
`default_nettype none
module nvm_access_properties
    import nvm_access_pkg::*;
#(
    parameter int WRITE_CYCLES_P = 8,
    parameter int POWER_UP_CYCLES_P = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // link signals
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq_high,
    input wire logic irq_low
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of key detector, permit, write timer and complete flag
    logic [1:0] key_q;
    logic permit_q;
    logic flag_q;
    logic en_q;
    logic pri_q;
    int busy_q;
    int pwr_q;
    wire logic wr_ctrl = wr && addr == REG_CONTROL;
    wire logic start = wr_ctrl && wdata[CTRL_WRITE_TRIGGER] && key_q == 2'h2 && permit_q
        && wdata[7:6] == 2'h0 && busy_q == 0 && pwr_q >= POWER_UP_CYCLES_P;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_q <= 2'h0;
            permit_q <= 1'b0;
            flag_q <= 1'b0;
            en_q <= 1'b0;
            pri_q <= 1'b0;
            busy_q <= 0;
            pwr_q <= 0;
        end else begin
            if (pwr_q < POWER_UP_CYCLES_P) pwr_q <= pwr_q + 1;
            if (wr) key_q <= (addr != REG_UNLOCK || busy_q != 0) ? 2'h0 : (wdata == KEY_FIRST) ? 2'h1
                : (wdata == KEY_SECOND && key_q == 2'h1) ? 2'h2 : 2'h0;
            if (wr_ctrl && busy_q == 0) permit_q <= wdata[CTRL_WRITE_PERMIT];
            busy_q <= start ? WRITE_CYCLES_P : (busy_q != 0) ? busy_q - 1 : 0;
            if (busy_q == 1) flag_q <= 1'b1;
            else if (wr && addr == REG_FLAGS_B) flag_q <= wdata[IRQ_WRITE_COMPLETE];
            if (wr && addr == REG_ENABLES_B) en_q <= wdata[IRQ_WRITE_COMPLETE];
            if (wr && addr == REG_PRIORITIES_B) pri_q <= wdata[IRQ_WRITE_COMPLETE];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rdata_quiet; !rd |=> rdata == 8'h00; endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");
    property p_unlock_zero; rd && addr == REG_UNLOCK |=> rdata == 8'h00; endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port reads nonzero");
    property p_busy_one; rd && addr == REG_CONTROL && busy_q != 0 |=> rdata[CTRL_WRITE_TRIGGER]; endproperty
    a_busy_one: assert property (p_busy_one) else $error("trigger low during write");
    property p_done_zero; rd && addr == REG_CONTROL && busy_q == 0 |=> !rdata[CTRL_WRITE_TRIGGER]; endproperty
    a_done_zero: assert property (p_done_zero) else $error("trigger high when idle");
    property p_permit; rd && addr == REG_CONTROL |=> rdata[CTRL_WRITE_PERMIT] == $past(permit_q); endproperty
    a_permit: assert property (p_permit) else $error("write permit changed by hardware");
    property p_irq_split; !(irq_high && irq_low); endproperty
    a_irq_split: assert property (p_irq_split) else $error("both request levels high");
    property p_irq_flag; irq_high || irq_low |-> flag_q; endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("request without complete flag");
    property p_irq_level; {irq_high, irq_low} == {flag_q && en_q && pri_q, flag_q && en_q && !pri_q}; endproperty
    a_irq_level: assert property (p_irq_level) else $error("request level wrong for flag and enable");
    property p_keys; wr_ctrl && wdata[CTRL_WRITE_TRIGGER] |-> key_q == 2'h2; endproperty
    a_keys: assert property (p_keys) else $error("trigger without unlock keys");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for both ends of the memory access link
`timescale 1ns/100ps
`default_nettype none
module tb;
    import nvm_access_pkg::*;
    localparam int WR = 8;
    localparam int PU = 40;
    logic clk, resetn, sw_we, sw_re, cp, ext_rd, ext_wr, irq, ext_ack, ext_den, busy, ack, den;
    logic [2:0] sw_addr;
    logic [7:0] sw_wdata, sw_rdata, ext_addr, ext_wdata, ext_rdata, a, v, xd, rv, st;
    int err_count, n_checks, n;
    nvm_bus_if bus_if();
    nvm_access_ctrl #(.WRITE_CYCLES_P(WR), .POWER_UP_CYCLES_P(PU)) i_nvm_access_ctrl (.sys_clk_i(clk),
        .resetn_i(resetn), .bus(bus_if.dev), .code_protect_i(cp), .ext_rd_i(ext_rd), .ext_wr_i(ext_wr),
        .ext_addr_i(ext_addr), .ext_wdata_i(ext_wdata), .ext_rdata_o(ext_rdata), .ext_ack_o(ext_ack),
        .ext_denied_o(ext_den), .write_busy_o(busy));
    nvm_cpu_end i_nvm_cpu_end (.sys_clk_i(clk), .resetn_i(resetn), .bus(bus_if.cpu), .sw_addr_i(sw_addr),
        .sw_wdata_i(sw_wdata), .sw_we_i(sw_we), .sw_re_i(sw_re), .sw_rdata_o(sw_rdata), .irq_o(irq));
    nvm_access_properties #(.WRITE_CYCLES_P(WR), .POWER_UP_CYCLES_P(PU)) i_nvm_access_properties (
        .sys_clk_i(clk), .resetn_i(resetn), .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
        .rd(bus_if.rd), .rdata(bus_if.rdata), .irq_high(bus_if.irq_high), .irq_low(bus_if.irq_low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
        n++;
        if (n > 300) begin
            err_count++;
            $display("[FAIL] %0t wait expired", $time);
            test_done();
        end
    endtask
    function automatic logic [7:0] done_st(input int bitpos);
        return 8'h01 << bitpos;
    endfunction
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
    endtask
    task automatic sw_wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge clk);
        sw_addr <= ad;
        sw_wdata <= d;
        sw_we <= 1'b1;
        @(posedge clk);
        sw_we <= 1'b0;
    endtask
    task automatic sw_rd(input logic [2:0] ad, output logic [7:0] d);
        @(posedge clk);
        sw_addr <= ad;
        sw_re <= 1'b1;
        @(posedge clk);
        sw_re <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic ext_op(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        ext_rd <= !w;
        ext_wr <= w;
        ext_addr <= ad;
        ext_wdata <= d;
        @(posedge clk);
        ext_rd <= 1'b0;
        ext_wr <= 1'b0;
        ext_addr <= ~ad;
        ext_wdata <= ~d;
        #1 ack = ext_ack === 1'b1;
        den = ext_den === 1'b1;
        @(posedge clk);
        #1 ack = ack || ext_ack === 1'b1;
        den = den || ext_den === 1'b1;
        xd = ext_rdata;
    endtask
    task automatic host_cmd(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] cmd);
        sw_wr(HREG_ADDRESS, ad);
        sw_wr(HREG_WRITE_DATA, d);
        sw_wr(HREG_COMMAND, cmd);
    endtask
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1) tick();
    endtask
    task automatic busy_len(input logic poke);
        n = 0;
        while (busy !== 1'b1) tick();
        if (poke) begin
            ext_op(1'b1, a, ~v);
            check(8'({ack, den}), 8'h01);
        end
        n = 0;
        while (busy === 1'b1) tick();
    endtask
    task automatic host_write(input logic poke);
        host_cmd(a, v, 8'h02);
        busy_len(poke);
        if (!poke) check(8'(n), 8'(WR));
        wait_irq();
        sw_rd(HREG_STATUS, st);
        check(st, done_st(ST_WRITE_DONE));
    endtask
    task automatic host_read(input logic [7:0] ad);
        host_cmd(ad, 8'h00, 8'h01);
        wait_irq();
        sw_rd(HREG_STATUS, st);
        check(st, done_st(ST_READ_DONE));
        sw_rd(HREG_READ_DATA, rv);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        {sw_we, sw_re, cp, ext_rd, ext_wr} = 5'h00;
        sw_addr = 3'h0;
        {sw_wdata, ext_addr, ext_wdata} = 24'h000000;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'h268D20D1));
        do_reset();
        repeat (PU + 10) @(posedge clk);
        sw_wr(HREG_MASK, 8'h03);
        // corner then random bytes, read back on both paths
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            host_write(i == 2);
            ext_op(1'b0, a, 8'h00);
            check(8'({ack, den}), 8'h02);
            check(xd, v);
            host_read(a);
            check(rv, v);
        end
        // masked completion
        sw_wr(HREG_MASK, 8'h00);
        host_cmd(a, ~v, 8'h02);
        busy_len(1'b0);
        repeat (20) @(posedge clk);
        #1 check(8'(irq), 8'h00);
        sw_rd(HREG_STATUS, st);
        check(st, done_st(ST_WRITE_DONE));
        sw_rd(HREG_STATUS, st);
        check(st, 8'h00);
        sw_wr(HREG_MASK, 8'h03);
        // code protect on, then off
        @(posedge clk);
        cp <= 1'b1;
        ext_op(1'b0, a, 8'h00);
        check(8'({ack, den}), 8'h01);
        ext_op(1'b1, a, v);
        check(8'({ack, den}), 8'h01);
        host_read(a);
        check(rv, ~v);
        @(posedge clk);
        cp <= 1'b0;
        ext_op(1'b1, a, 8'hC3);
        check(8'({ack, den}), 8'h02);
        host_read(a);
        check(rv, 8'hC3);
        // write inside the power-up time after a second reset
        do_reset();
        sw_wr(HREG_MASK, 8'h03);
        host_cmd(a, 8'h3C, 8'h02);
        wait_irq();
        sw_rd(HREG_STATUS, st);
        repeat (PU) @(posedge clk);
        host_read(a);
        check(rv, 8'hC3);
        test_done();
    end
endmodule
`default_nettype wire
